// *** inc/keyer_pkg.sv ***
// Constants and encodings shared by the signal keyer design.
// Assumes a single 250 MHz clock domain and no register bus; controls are ports.
package keyer_pkg;

  // Keying source codes
  localparam logic [3:0] KEY_SRC_SOFT_BIT = 4'h0;
  localparam logic [3:0] KEY_SRC_EXT_PIN = 4'h1;
  localparam logic [3:0] KEY_SRC_CAPCMP = 4'h2;
  localparam logic [3:0] KEY_SRC_SERIAL = 4'h3;
  localparam logic [3:0] KEY_SRC_CMP1 = 4'h4;
  localparam logic [3:0] KEY_SRC_CMP2 = 4'h5;
  localparam logic [3:0] KEY_SRC_UART_TX = 4'h6;

  // Carrier source codes
  localparam logic [3:0] CAR_SRC_GROUND = 4'h0;
  localparam logic [3:0] CAR_SRC_EXT_ONE = 4'h1;
  localparam logic [3:0] CAR_SRC_EXT_TWO = 4'h2;
  localparam logic [3:0] CAR_SRC_REFCLK = 4'h3;
  localparam logic [3:0] CAR_SRC_CAPCMP = 4'h4;

  // Peripheral index used for pin disconnect routing
  localparam int PERIPH_COUNT = 6;
  localparam int PERIPH_CAPCMP = 0;
  localparam int PERIPH_SERIAL = 1;
  localparam int PERIPH_CMP1 = 2;
  localparam int PERIPH_CMP2 = 3;
  localparam int PERIPH_UART_TX = 4;
  localparam int PERIPH_REFCLK = 5;

  // Reset values of the control bits
  localparam logic RST_OUTPUT_SLEW_LIMIT = 1'b1;
  localparam logic RST_OUTPUT = 1'b0;

endpackage

// *** hw/keyer_source_mux.sv ***
// Source selector for the keying signal and one carrier.
// Assumes all inputs already lie in the clk domain.
`timescale 1ns/1ns
`default_nettype none
module keyer_source_mux (
  input wire logic [3:0] keying_source_select, // Keying source code
  input wire logic [3:0] carrier_select, // Carrier source code for one carrier
  input wire logic soft_keying_bit, // Software keying level
  input wire logic external_keying_pin, // Synchronised keying pin
  input wire logic external_carrier_pin_one, // Synchronised carrier pin one
  input wire logic external_carrier_pin_two, // Synchronised carrier pin two
  input wire logic capture_compare_output, // Capture/compare output
  input wire logic serial_data_out, // SPI data out
  input wire logic cmp1_out, // Comparator 1
  input wire logic cmp2_out, // Comparator 2
  input wire logic uart_tx, // UART transmit line
  input wire logic refclk_out, // Reference clock output
  output logic keying_sel, // Selected keying level
  output logic carrier_sel // Selected carrier level
);

  // Keying decode; unused codes fall back to the soft bit
  always_comb begin
    unique case (keying_source_select)
      keyer_pkg::KEY_SRC_EXT_PIN: keying_sel = external_keying_pin;
      keyer_pkg::KEY_SRC_CAPCMP: keying_sel = capture_compare_output;
      keyer_pkg::KEY_SRC_SERIAL: keying_sel = serial_data_out;
      keyer_pkg::KEY_SRC_CMP1: keying_sel = cmp1_out;
      keyer_pkg::KEY_SRC_CMP2: keying_sel = cmp2_out;
      keyer_pkg::KEY_SRC_UART_TX: keying_sel = uart_tx;
      default: keying_sel = soft_keying_bit;
    endcase
  end

  // Carrier decode; unused codes read as ground
  always_comb begin
    unique case (carrier_select)
      keyer_pkg::CAR_SRC_EXT_ONE: carrier_sel = external_carrier_pin_one;
      keyer_pkg::CAR_SRC_EXT_TWO: carrier_sel = external_carrier_pin_two;
      keyer_pkg::CAR_SRC_REFCLK: carrier_sel = refclk_out;
      keyer_pkg::CAR_SRC_CAPCMP: carrier_sel = capture_compare_output;
      default: carrier_sel = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

// *** hw/keyer_sync2.sv ***
// Two-flop synchroniser for a bundle of pin levels.
// Assumes the levels are asynchronous to clk.
`timescale 1ns/1ns
`default_nettype none
module keyer_sync2 (
  input wire logic clk, // System clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic [2:0] async_in, // Pin levels
  output logic [2:0] sync_out // Synchronised levels
);

  logic [2:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 3'h0;
      sync_out <= 3'h0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule
`default_nettype wire

// *** hw/signal_keyer.sv ***
// Signal keyer: mixes a keying stream with one of two carriers onto a pin.
// Assumes on-chip peripheral signals are in the clk domain; pins are not.
`timescale 1ns/1ns
`default_nettype none
module signal_keyer (
  input wire logic clk, // 250 MHz system clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic module_enable_bit, // Keyer enable
  input wire logic output_drive_enable, // Pin output enable
  input wire logic output_slew_limit, // Slew limit request
  input wire logic output_invert, // Output polarity
  input wire logic soft_keying_bit, // Programmable keying level
  input wire logic [3:0] keying_source_select, // Keying source code
  input wire logic keying_source_pin_disconnect, // Detach keying peripheral pin
  input wire logic [3:0] upper_carrier_select, // Upper carrier source code
  input wire logic upper_carrier_sync_enable, // Upper carrier sync
  input wire logic upper_carrier_invert, // Upper carrier polarity
  input wire logic upper_carrier_pin_disconnect, // Detach upper source pin
  input wire logic [3:0] lower_carrier_select, // Lower carrier source code
  input wire logic lower_carrier_sync_enable, // Lower carrier sync
  input wire logic lower_carrier_invert, // Lower carrier polarity
  input wire logic lower_carrier_pin_disconnect, // Detach lower source pin
  input wire logic external_keying_pin, // Keying pin, asynchronous
  input wire logic external_carrier_pin_one, // Carrier pin one, asynchronous
  input wire logic external_carrier_pin_two, // Carrier pin two, asynchronous
  input wire logic capture_compare_output, // Capture/compare output
  input wire logic serial_data_out, // SPI data out
  input wire logic cmp1_out, // Comparator 1
  input wire logic cmp2_out, // Comparator 2
  input wire logic uart_tx, // UART transmit
  input wire logic refclk_out, // Reference clock output
  output logic keyed_output_pin, // Modulated pin level
  output logic keyed_output_oe, // Pin output enable
  output logic keyed_output_slew, // Pin slew limiting on
  output logic keyed_output_status, // Mixed level before gating
  output logic [5:0] periph_pin_disconnect // Per-peripheral pin detach
);

  typedef enum logic [1:0] {
    ACT_UPPER,
    ACT_LOWER,
    ACT_BOTH
  } active_e;

  logic [2:0] pins_sync;
  logic keying_raw;
  logic upper_raw;
  logic lower_raw;
  logic keying;
  logic upper;
  logic lower;
  logic [3:0] eff_key_sel;
  logic [3:0] eff_upper_sel;
  logic [3:0] eff_lower_sel;
  active_e active;
  active_e next_active;
  logic carrier;
  logic mixed;
  logic [5:0] next_disc;

  // Pins cross into clk before any logic reads them
  keyer_sync2 u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({external_carrier_pin_two, external_carrier_pin_one, external_keying_pin}),
    .sync_out(pins_sync)
  );

  // Disabled keyer grounds carriers and keys from the soft bit; stored
  // selections stay on the ports so re-enabling reapplies them
  always_comb begin
    if (module_enable_bit) begin
      eff_key_sel = keying_source_select;
      eff_upper_sel = upper_carrier_select;
      eff_lower_sel = lower_carrier_select;
    end else begin
      eff_key_sel = keyer_pkg::KEY_SRC_SOFT_BIT;
      eff_upper_sel = keyer_pkg::CAR_SRC_GROUND;
      eff_lower_sel = keyer_pkg::CAR_SRC_GROUND;
    end
  end

  // Upper path also yields the keying level
  keyer_source_mux u_upper_mux (
    .keying_source_select(eff_key_sel),
    .carrier_select(eff_upper_sel),
    .soft_keying_bit(soft_keying_bit),
    .external_keying_pin(pins_sync[0]),
    .external_carrier_pin_one(pins_sync[1]),
    .external_carrier_pin_two(pins_sync[2]),
    .capture_compare_output(capture_compare_output),
    .serial_data_out(serial_data_out),
    .cmp1_out(cmp1_out),
    .cmp2_out(cmp2_out),
    .uart_tx(uart_tx),
    .refclk_out(refclk_out),
    .keying_sel(keying_raw),
    .carrier_sel(upper_raw)
  );

  keyer_source_mux u_lower_mux (
    .keying_source_select(eff_key_sel),
    .carrier_select(eff_lower_sel),
    .soft_keying_bit(soft_keying_bit),
    .external_keying_pin(pins_sync[0]),
    .external_carrier_pin_one(pins_sync[1]),
    .external_carrier_pin_two(pins_sync[2]),
    .capture_compare_output(capture_compare_output),
    .serial_data_out(serial_data_out),
    .cmp1_out(cmp1_out),
    .cmp2_out(cmp2_out),
    .uart_tx(uart_tx),
    .refclk_out(refclk_out),
    .keying_sel(),
    .carrier_sel(lower_raw)
  );

  // Carrier polarity applies to the selected source only
  assign keying = keying_raw;
  assign upper = upper_raw ^ (upper_carrier_invert & module_enable_bit);
  assign lower = lower_raw ^ (lower_carrier_invert & module_enable_bit);

  // Active carrier tracking. With sync on for the outgoing carrier it stays
  // in use (both state) until its pulse falls; low keying still masks an outgoing upper pulse.
  always_comb begin
    next_active = active;
    unique case (active)
      ACT_UPPER: begin
        if (!keying) begin
          if (upper_carrier_sync_enable && upper) begin
            next_active = ACT_BOTH;
          end else begin
            next_active = ACT_LOWER;
          end
        end
      end
      ACT_LOWER: begin
        if (keying) begin
          if (lower_carrier_sync_enable && lower) begin
            next_active = ACT_BOTH;
          end else begin
            next_active = ACT_UPPER;
          end
        end
      end
      ACT_BOTH: begin
        // Outgoing carrier is the opposite of the current keying level
        if (keying && !lower) begin
          next_active = ACT_UPPER;
        end else if (!keying && !upper) begin
          next_active = ACT_LOWER;
        end
      end
      default: next_active = ACT_LOWER;
    endcase
  end

  // Reset leaves the lower carrier active with the keyer quiet
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active <= ACT_LOWER;
    end else begin
      active <= next_active;
    end
  end

  // Pick the carrier in use; in the both state the outgoing one finishes
  always_comb begin
    unique case (active)
      ACT_UPPER: carrier = upper;
      ACT_LOWER: carrier = lower;
      ACT_BOTH: carrier = keying ? lower : upper;
      default: carrier = 1'b0;
    endcase
  end

  // Mixing: keying gates the carrier; inversion sits before output gating
  assign mixed = (carrier & keying) ^ output_invert;

  // Pin drive; mixing runs regardless of the output enable. No clock gating
  // is used, so the keyer keeps running while the core sleeps.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      keyed_output_pin <= keyer_pkg::RST_OUTPUT;
      keyed_output_status <= keyer_pkg::RST_OUTPUT;
    end else begin
      keyed_output_status <= mixed;
      keyed_output_pin <= output_drive_enable & module_enable_bit & mixed;
    end
  end

  // Pin control: enable follows the drive bit gated by the keyer enable, slew follows its bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      keyed_output_oe <= 1'b0;
      keyed_output_slew <= keyer_pkg::RST_OUTPUT_SLEW_LIMIT;
    end else begin
      keyed_output_oe <= output_drive_enable & module_enable_bit;
      keyed_output_slew <= output_slew_limit;
    end
  end

  // Map a carrier code onto the peripheral it draws from
  function automatic logic [5:0] carrier_periph(input logic [3:0] sel);
    logic [5:0] m;
    m = 6'h00;
    if (sel == keyer_pkg::CAR_SRC_CAPCMP) begin
      m[keyer_pkg::PERIPH_CAPCMP] = 1'b1;
    end
    if (sel == keyer_pkg::CAR_SRC_REFCLK) begin
      m[keyer_pkg::PERIPH_REFCLK] = 1'b1;
    end
    return m;
  endfunction

  // Detach requests for the peripherals that feed the selected sources
  always_comb begin
    next_disc = 6'h00;
    if (module_enable_bit) begin
      if (upper_carrier_pin_disconnect) begin
        next_disc = next_disc | carrier_periph(upper_carrier_select);
      end
      if (lower_carrier_pin_disconnect) begin
        next_disc = next_disc | carrier_periph(lower_carrier_select);
      end
      if (keying_source_pin_disconnect) begin
        unique case (keying_source_select)
          keyer_pkg::KEY_SRC_CAPCMP: next_disc[keyer_pkg::PERIPH_CAPCMP] = 1'b1;
          keyer_pkg::KEY_SRC_SERIAL: next_disc[keyer_pkg::PERIPH_SERIAL] = 1'b1;
          keyer_pkg::KEY_SRC_CMP1: next_disc[keyer_pkg::PERIPH_CMP1] = 1'b1;
          keyer_pkg::KEY_SRC_CMP2: next_disc[keyer_pkg::PERIPH_CMP2] = 1'b1;
          keyer_pkg::KEY_SRC_UART_TX: next_disc[keyer_pkg::PERIPH_UART_TX] = 1'b1;
          default: next_disc = next_disc;
        endcase
      end
    end
  end

  // Registered so the pin muxes see a clean level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      periph_pin_disconnect <= 6'h00;
    end else begin
      periph_pin_disconnect <= next_disc;
    end
  end

endmodule
`default_nettype wire

// *** tb/keyer_checker_sva.sv ***
// Concurrent checks on the signal keyer top ports.
// Assumes one clock domain and the keyer package source encodings.
`timescale 1ns/1ns
`default_nettype none
module keyer_checker (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic module_enable_bit, // Keyer enable
  input wire logic output_drive_enable, // Pin drive enable
  input wire logic output_slew_limit, // Slew request
  input wire logic output_invert, // Output polarity
  input wire logic soft_keying_bit, // Soft keying level
  input wire logic [3:0] keying_source_select, // Keying source
  input wire logic keying_source_pin_disconnect, // Keying detach
  input wire logic [3:0] upper_carrier_select, // Upper source
  input wire logic upper_carrier_invert, // Upper polarity
  input wire logic [3:0] lower_carrier_select, // Lower source
  input wire logic lower_carrier_invert, // Lower polarity
  input wire logic lower_carrier_sync_enable, // Lower sync
  input wire logic keyed_output_pin, // Pin level
  input wire logic keyed_output_oe, // Pin enable
  input wire logic keyed_output_slew, // Slew on
  input wire logic keyed_output_status, // Mixed level
  input wire logic [5:0] periph_pin_disconnect // Detach bits
);
  logic run_ok;

  // Flops still sit in reset at the release edge, so checks start one edge later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_ok <= 1'b0;
    end else begin
      run_ok <= 1'b1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n || !run_ok);

  // Enables and pin gating
  oe_on_a: assert property ((output_drive_enable && module_enable_bit) |=> keyed_output_oe)
    else $error("pin enable missing");
  drive_low_a: assert property (!output_drive_enable |=> !keyed_output_pin && !keyed_output_oe)
    else $error("pin not low with drive off");
  disabled_quiet_a: assert property (!module_enable_bit |=>
    !keyed_output_pin && !keyed_output_oe && periph_pin_disconnect == 6'h00)
    else $error("disabled keyer still active");
  slew_on_a: assert property (output_slew_limit |=> keyed_output_slew)
    else $error("slew limit not applied");
  slew_off_a: assert property (!output_slew_limit |=> !keyed_output_slew)
    else $error("slew limit not removed");
  // A high pin needs a high mixed level, so invert sits before the gate
  pin_gated_a: assert property (keyed_output_pin |-> keyed_output_status && keyed_output_oe)
    else $error("pin high without mixed level");
  key_low_a: assert property ((keying_source_select == keyer_pkg::KEY_SRC_SOFT_BIT &&
    !soft_keying_bit && !output_invert) |=> !keyed_output_status)
    else $error("mixed level high with keying low");
  out_invert_a: assert property ((upper_carrier_select == 4'h0 &&
    lower_carrier_select == 4'h0 && !upper_carrier_invert && !lower_carrier_invert)
    |=> keyed_output_status == $past(output_invert))
    else $error("output polarity wrong");
  // Three cycles covers the carrier switch and the output flop
  upper_pick_a: assert property ((module_enable_bit && soft_keying_bit &&
    keying_source_select == 4'h0 && upper_carrier_select == 4'h0 && upper_carrier_invert &&
    !lower_carrier_sync_enable && !output_invert)[*3] |=> keyed_output_status)
    else $error("upper carrier not used");
  key_detach_a: assert property ((module_enable_bit && keying_source_pin_disconnect &&
    keying_source_select == keyer_pkg::KEY_SRC_CAPCMP) |=> periph_pin_disconnect[0])
    else $error("keying peripheral still on pin");

  cover property (module_enable_bit && output_drive_enable ##1 keyed_output_pin);
  cover property (!output_drive_enable ##1 keyed_output_status);
  cover property (!module_enable_bit ##1 module_enable_bit ##2 keyed_output_pin);
endmodule
`default_nettype wire

// *** tb/keyer_source_model.sv ***
// Far-side model: external keying and carrier pins plus the reference clock.
// Assumes the bench asks for levels; they appear one edge later.
`timescale 1ns/1ns
`default_nettype none
module keyer_source_model (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic want_key, // Keying pin request
  input wire logic want_one, // Carrier pin one request
  input wire logic want_two, // Carrier pin two request
  input wire logic want_ref, // Reference clock request
  output logic external_keying_pin, // Keying pin
  output logic external_carrier_pin_one, // Carrier pin one
  output logic external_carrier_pin_two, // Carrier pin two
  output logic refclk_out // Reference clock
);
  // Registered so that the pins never move in the edge that samples them
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {external_keying_pin, external_carrier_pin_one} <= 2'h0;
      {external_carrier_pin_two, refclk_out} <= 2'h0;
    end else begin
      {external_keying_pin, external_carrier_pin_one} <= {want_key, want_one};
      {external_carrier_pin_two, refclk_out} <= {want_two, want_ref};
    end
  end
endmodule
`default_nettype wire

// *** tb/signal_keyer_test.sv ***
// Self-checking bench: source tables, carriers, gating, sync and reset.
// Assumes the keyer package encodings and a 250 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module signal_keyer_test;
  logic clk, rst_n, module_enable_bit, output_drive_enable, output_slew_limit, output_invert;
  logic soft_keying_bit, keying_source_pin_disconnect, upper_carrier_sync_enable;
  logic upper_carrier_invert, upper_carrier_pin_disconnect, lower_carrier_sync_enable;
  logic lower_carrier_invert, lower_carrier_pin_disconnect, capture_compare_output;
  logic serial_data_out, cmp1_out, cmp2_out, uart_tx, want_key, want_one, want_two, want_ref;
  logic [3:0] keying_source_select, upper_carrier_select, lower_carrier_select;
  wire logic external_keying_pin, external_carrier_pin_one, external_carrier_pin_two, refclk_out;
  wire logic keyed_output_pin, keyed_output_oe, keyed_output_slew, keyed_output_status;
  wire logic [5:0] periph_pin_disconnect;
  wire logic [5:0] outs = {2'h0, keyed_output_pin, keyed_output_oe, keyed_output_slew,
    keyed_output_status};
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;

  signal_keyer u_dut (.*);
  keyer_source_model u_src (.*);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input logic [5:0] got, input logic [5:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Pin sources need up to five cycles, so eight leaves margin
  task automatic settle;
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Chosen keying source gets v, all others its inverse
  task automatic set_key(input int k, input logic v);
    @(posedge clk);
    keying_source_select <= 4'(k);
    soft_keying_bit <= (k == 0) ? v : ~v;
    want_key <= (k == 1) ? v : ~v;
    capture_compare_output <= (k == 2) ? v : ~v;
    serial_data_out <= (k == 3) ? v : ~v;
    {cmp1_out, cmp2_out} <= {(k == 4) ? v : ~v, (k == 5) ? v : ~v};
    uart_tx <= (k == 6) ? v : ~v;
  endtask

  initial begin
    {rst_n, module_enable_bit, output_drive_enable, output_invert, soft_keying_bit} = '0;
    {keying_source_pin_disconnect, upper_carrier_sync_enable, upper_carrier_invert} = '0;
    {upper_carrier_pin_disconnect, lower_carrier_sync_enable, lower_carrier_invert} = '0;
    {lower_carrier_pin_disconnect, capture_compare_output, serial_data_out, cmp1_out} = '0;
    {cmp2_out, uart_tx, want_key, want_one, want_two, want_ref} = '0;
    {keying_source_select, upper_carrier_select, lower_carrier_select} = '0;
    output_slew_limit = 1'b1;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    settle();
    check(outs, 6'h02);
    check(periph_pin_disconnect, 6'h00);
    @(posedge clk);
    {module_enable_bit, output_drive_enable, keying_source_pin_disconnect, want_one} <= 4'hf;
    upper_carrier_select <= keyer_pkg::CAR_SRC_EXT_ONE;
    for (int k = 0; k < 14; k++) begin
      set_key(k / 2, k[0]);
      settle();
      check(outs, k[0] ? 6'h0f : 6'h06);
      check(periph_pin_disconnect, (k > 3) ? 6'(1 << (k / 2 - 2)) : 6'h00);
    end
    set_key(0, 1'b1);
    {upper_carrier_pin_disconnect, lower_carrier_pin_disconnect} <= 2'h3;
    for (int c = 0; c < 5; c++) begin
      @(posedge clk);
      {want_one, want_two, want_ref, capture_compare_output} <= 4'(8 >> (c - 1));
      {upper_carrier_select, lower_carrier_select} <= {4'(c), 4'h0};
      settle();
      check(outs, (c != 0) ? 6'h0f : 6'h06);
      check(periph_pin_disconnect, (c == 3) ? 6'h20 : (c == 4) ? 6'h01 : 6'h00);
      @(posedge clk);
      {upper_carrier_select, lower_carrier_select} <= {4'h0, 4'(c)};
      settle();
      check(outs, 6'h06);
      check(periph_pin_disconnect, (c == 3) ? 6'h20 : (c == 4) ? 6'h01 : 6'h00);
    end
    @(posedge clk);
    {lower_carrier_select, upper_carrier_invert} <= {4'h0, 1'b1};
    settle();
    check(outs, 6'h0f);
    @(posedge clk);
    {upper_carrier_invert, output_invert} <= 2'h1;
    settle();
    check(outs, 6'h0f);
    @(posedge clk);
    output_drive_enable <= 1'b0;
    settle();
    check(outs, 6'h03);
    @(posedge clk);
    output_slew_limit <= 1'b0;
    settle();
    check(outs, 6'h01);
    @(posedge clk);
    {output_drive_enable, output_slew_limit, output_invert, module_enable_bit} <= 4'hc;
    {upper_carrier_select, capture_compare_output} <= {keyer_pkg::CAR_SRC_CAPCMP, 1'b1};
    settle();
    check(outs, 6'h02);
    check(periph_pin_disconnect, 6'h00);
    @(posedge clk);
    module_enable_bit <= 1'b1;
    settle();
    check(outs, 6'h0f);
    check(periph_pin_disconnect, 6'h01);
    @(posedge clk);
    {upper_carrier_select, lower_carrier_select} <= {4'h0, keyer_pkg::CAR_SRC_CAPCMP};
    {lower_carrier_sync_enable, soft_keying_bit} <= 2'h2;
    settle();
    @(posedge clk);
    soft_keying_bit <= 1'b1;
    settle();
    check(outs, 6'h0f);
    @(posedge clk);
    capture_compare_output <= 1'b0;
    settle();
    check(outs, 6'h06);
    @(posedge clk);
    capture_compare_output <= 1'b1;
    settle();
    check(outs, 6'h06);
    @(posedge clk);
    {lower_carrier_sync_enable, upper_carrier_sync_enable, soft_keying_bit} <= 3'h2;
    settle();
    @(posedge clk);
    soft_keying_bit <= 1'b1;
    settle();
    check(outs, 6'h06);
    @(posedge clk);
    rst_n <= 1'b0;
    @(negedge clk);
    check(outs, 6'h02);
    check(periph_pin_disconnect, 6'h00);
    @(posedge clk);
    rst_n <= 1'b1;
    settle();
    // Controls still stand after the reset pulse, so outputs follow them again
    check(outs, 6'h06);
    check(periph_pin_disconnect, 6'h01);
    complete_run();
  end

  // Whole run is about 350 cycles; the ceiling cuts a hang short
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      complete_run();
    end
  end
endmodule

bind signal_keyer keyer_checker u_chk (.*);
`default_nettype wire
